//--- rtl/ccpt_pkg.sv
/*
  Package for the Timer3 and two-unit capture/compare/PWM block: register
  offsets, control field positions, reset values, mode codes and state types.
  Assumes a 32-bit Wishbone slave with byte addresses and data in lane 0.
*/
`default_nettype none

package ccpt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_T3_LOW     = 8'h00; // Timer3 count, low byte
  localparam logic [7:0] OFS_T3_HIGH    = 8'h04; // Timer3 count, high byte
  localparam logic [7:0] OFS_T3_CTRL    = 8'h08; // Timer3 control
  localparam logic [7:0] OFS_IRQ_REQ2   = 8'h0c; // Overflow flag register
  localparam logic [7:0] OFS_IRQ_EN2    = 8'h10; // Overflow enable register
  localparam logic [7:0] OFS_U1_CTRL    = 8'h14; // Unit one mode control
  localparam logic [7:0] OFS_U1_LOW     = 8'h18; // Unit one data low
  localparam logic [7:0] OFS_U1_HIGH    = 8'h1c; // Unit one data high
  localparam logic [7:0] OFS_U2_CTRL    = 8'h20; // Unit two mode control
  localparam logic [7:0] OFS_U2_LOW     = 8'h24; // Unit two data low
  localparam logic [7:0] OFS_U2_HIGH    = 8'h28; // Unit two data high
  localparam logic [7:0] OFS_AUX_CTRL   = 8'h2c; // Oscillator and converter enables
  localparam logic [7:0] OFS_UNIT_FLAGS = 8'h30; // Unit event flags
  localparam logic [7:0] UNIT_STRIDE    = 8'h0c; // Distance between unit blocks

  // Timer3 control field positions
  localparam int T3C_RUN  = 0;
  localparam int T3C_CS   = 1;
  localparam int T3C_SYNC = 2;
  localparam int T3C_SEL1 = 3;
  localparam int T3C_PS   = 4; // Two bits, 5:4
  localparam int T3C_SEL2 = 6;
  localparam int T3C_RD16 = 7;

  // Other field positions
  localparam int IRQ_T3_OVF  = 1; // Overflow flag and enable bit
  localparam int AUX_OSC_EN  = 0;
  localparam int AUX_ADC_EN  = 1;
  localparam int UCTRL_DC    = 4; // Duty fraction bits 5:4

  // Cycle counts
  localparam logic [1:0] INSTR_PHASE_LAST = 2'h3; // Fosc/4: one tick per four clocks
  localparam logic [3:0] CAP_EVERY_4TH    = 4'h3;
  localparam logic [3:0] CAP_EVERY_16TH   = 4'hf;
  localparam logic [15:0] T3_TOP          = 16'hffff;

  // Unit mode codes
  typedef enum logic [3:0] {
    M_OFF      = 4'h0, M_RSV1     = 4'h1, M_TOGGLE   = 4'h2, M_RSV3     = 4'h3,
    M_CAP_FALL = 4'h4, M_CAP_RISE = 4'h5, M_CAP_R4   = 4'h6, M_CAP_R16  = 4'h7,
    M_SET_HIGH = 4'h8, M_SET_LOW  = 4'h9, M_SOFT     = 4'ha, M_SPECIAL  = 4'hb,
    M_PWM0     = 4'hc, M_PWM1     = 4'hd, M_PWM2     = 4'he, M_PWM3     = 4'hf
  } ccpt_mode_t;

  // Per-unit state
  typedef struct packed {
    logic [1:0]  dc;        // Duty fraction bits
    ccpt_mode_t  mode;      // Current mode
    ccpt_mode_t  mode_prev; // Mode seen last cycle, for entry actions
    logic [15:0] data;      // Capture, compare or duty register
    logic        out;       // Compare output level
    logic        oe;        // Block drives the pin
    logic        flag;      // Sticky event flag
    logic        eq_prev;   // Equality seen last cycle
    logic [3:0]  psc;       // Capture edge prescaler
    logic [2:0]  sync;      // Pin synchroniser
    logic        lvl;       // Filtered pin level
    logic [9:0]  duty;      // Assembled PWM duty value
  } ccpt_unit_t;

  // Whole block state
  typedef struct packed {
    ccpt_unit_t [1:0] unit;
    logic [15:0] cnt;       // Timer3 count
    logic [7:0]  hi_buf;    // High byte buffer for 16-bit access
    logic [7:0]  timer3_control;     // Timer3 control
    logic        ovf_flag;  // Sticky overflow flag
    logic        ovf_en;    // Overflow interrupt enable
    logic        osc_en;    // Secondary oscillator enable
    logic        adc_en;    // Converter enable
    logic [2:0]  pre;       // Timer3 prescaler
    logic [1:0]  phase;     // Instruction cycle phase
    logic [2:0]  osc_sync;  // Oscillator synchroniser
    logic        osc_lvl;   // Filtered oscillator level
    logic        ack;       // Bus acknowledge
    logic [31:0] rdata;     // Bus read data
    logic        adc_start; // Conversion request pulse
    logic        t1_reset;  // Timer1 reset request pulse
    logic        irq;       // Overflow interrupt
  } ccpt_state_t;

  localparam ccpt_state_t STATE_RST = '0; // Every field resets to zero

endpackage

`default_nettype wire

//--- rtl/ccpt_timer3_ccp.sv
/*
  Timer3 with overflow flag plus the mode control of two capture/compare
  units, reached as a classic Wishbone slave. Assumes the Timer1 count arrives
  from logic on MCLK, and that the oscillator and unit pins are asynchronous.
*/
// Added by the designer: the Wishbone slave port and the register addresses.
// Behaviour
// - Oscillator enabled and source select: count oscillator edges
// - Count runs 0000h to FFFFh then wraps
// - Wrap sets sticky overflow flag; enable gates interrupt
// - Special-event match on Timer3 clears the count
// - Unit two special event also starts conversion
// - Special reset valid in timer and synchronous modes
// - Unit data register acts as Timer3 period
// - Software count write beats special-event reset
// - Special-event reset never sets overflow flag
// - Two units with 16-bit data register, alike except for converter start and time base select
// - Data halves and control readable and writable
// - PWM duty is low byte plus fraction bits
// - Mode 0000 disables and resets unit logic
// - Mode 0010 toggles output on match, sets flag
// - Modes 0100-0111 capture on selected edges
// - Mode 1000 starts low, match forces high
// - Mode 1001 starts high, match forces low
// - Mode 1010 only sets flag on match
// - Internal source counts once per instruction cycle
// - Select bits choose each unit's time base
// - Prescale divides by 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none

module ccpt_timer3_ccp
  import ccpt_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // External inputs
  input  wire logic        SEC_OSC_CLK,
  input  wire logic [15:0] TIMER1_COUNT,
  input  wire logic [1:0]  UNIT_PIN_IN,
  // Unit outputs
  output logic      [1:0]  UNIT_PIN_OUT,
  output logic      [1:0]  UNIT_PIN_OE,
  output logic      [9:0]  UNIT_ONE_DUTY,
  output logic      [9:0]  UNIT_TWO_DUTY,
  // Events
  output logic             ADC_START,
  output logic             TIMER1_RESET,
  output logic             TIMER3_IRQ
);

  ccpt_state_t s_q;      // Registered state
  ccpt_state_t s_d;      // Next state
  logic        bus_req;  // Request present
  logic        bus_do;   // Effect edge of an access
  logic        wr_en;    // Write taking effect
  logic        t3_inc;   // Timer3 advances this cycle
  logic        t3_wr;    // Software writes the count this cycle
  logic        t3_wrap;  // Natural wrap this cycle
  logic        t3_ser;   // Special-event reset request for Timer3
  logic [1:0]  match;    // Compare match event per unit
  logic [1:0]  capture;  // Capture event per unit

  // Unit idx uses Timer3 as time base
  function automatic logic uses_t3(input logic [7:0] con, input int idx);
    uses_t3 = con[T3C_SEL2] | (con[T3C_SEL1] & (idx == 1));
  endfunction

  // Last prescaler value before Timer3 advances
  function automatic logic [2:0] pre_limit(input logic [1:0] ps);
    case (ps)
      2'h0:    pre_limit = 3'h0;
      2'h1:    pre_limit = 3'h1;
      2'h2:    pre_limit = 3'h3;
      default: pre_limit = 3'h7;
    endcase
  endfunction

  // Mode compares against the time base
  function automatic logic is_compare(input ccpt_mode_t m);
    is_compare = (m == M_TOGGLE) | (m == M_SET_HIGH) | (m == M_SET_LOW) |
                 (m == M_SOFT) | (m == M_SPECIAL);
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic        src_tick;
    logic        osc_new;
    logic        lvl_new;
    logic [15:0] tb;
    logic        eq;
    logic        is_cap;
    logic        rise;
    logic        fall;
    logic [7:0]  a_ofs;
    logic [7:0]  rd;
    src_tick = 1'b0;
    osc_new  = 1'b0;
    lvl_new  = 1'b0;
    tb       = 16'h0000;
    eq       = 1'b0;
    is_cap   = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    a_ofs    = 8'h00;
    rd       = 8'h00;
    s_d      = s_q;
    match    = 2'b00;
    capture  = 2'b00;

    // Bus handshake: ack one cycle after the request, effects at ack edge
    bus_req = WB_CYC_I & WB_STB_I;
    bus_do  = bus_req & s_q.ack;
    wr_en   = bus_do & WB_WE_I & WB_SEL_I[0];
    s_d.ack = bus_req & ~s_q.ack;

    // Oscillator input: three flops, level changes when stages two and three agree
    s_d.osc_sync = {s_q.osc_sync[1:0], SEC_OSC_CLK};
    osc_new      = (s_q.osc_sync[1] == s_q.osc_sync[2]) ? s_q.osc_sync[2] : s_q.osc_lvl;
    s_d.osc_lvl  = osc_new;

    // Instruction cycle at a quarter of MCLK
    s_d.phase = s_q.phase + 2'h1;
    // Source tick; the oscillator is always resynchronised, so the
    // asynchronous setting still counts on MCLK and special resets hold
    if (s_q.timer3_control[T3C_CS]) begin
      src_tick = s_q.osc_en & osc_new & ~s_q.osc_lvl;
    end else begin
      src_tick = (s_q.phase == INSTR_PHASE_LAST);
    end

    // Prescaler and increment, only while running
    t3_inc = 1'b0;
    if (s_q.timer3_control[T3C_RUN] & src_tick) begin
      if (s_q.pre >= pre_limit(s_q.timer3_control[T3C_PS +: 2])) begin
        s_d.pre = 3'h0;
        t3_inc  = 1'b1;
      end else begin
        s_d.pre = s_q.pre + 3'h1;
      end
    end
    t3_wrap = t3_inc & (s_q.cnt == T3_TOP);
    if (t3_inc) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end

    // Units
    t3_ser = 1'b0;
    s_d.adc_start = 1'b0;
    s_d.t1_reset  = 1'b0;
    for (int i = 0; i < 2; i++) begin
      tb = uses_t3(s_q.timer3_control, i) ? s_q.cnt : TIMER1_COUNT;
      eq = (tb == s_q.unit[i].data);
      // Pin synchroniser and filter
      s_d.unit[i].sync = {s_q.unit[i].sync[1:0], UNIT_PIN_IN[i]};
      lvl_new = (s_q.unit[i].sync[1] == s_q.unit[i].sync[2]) ? s_q.unit[i].sync[2] : s_q.unit[i].lvl;
      s_d.unit[i].lvl = lvl_new;
      rise = lvl_new & ~s_q.unit[i].lvl;
      fall = ~lvl_new & s_q.unit[i].lvl;
      is_cap = (s_q.unit[i].mode[3:2] == 2'b01);
      s_d.unit[i].mode_prev = s_q.unit[i].mode;
      s_d.unit[i].eq_prev   = eq & is_compare(s_q.unit[i].mode);
      // One match per arrival at equality; reserved modes never compare
      match[i] = is_compare(s_q.unit[i].mode) & eq & ~s_q.unit[i].eq_prev;

      // Capture edge choice
      if (!is_cap) begin
        s_d.unit[i].psc = 4'h0; // Prescaler cleared outside capture
      end
      case (s_q.unit[i].mode)
        M_CAP_FALL: capture[i] = fall;
        M_CAP_RISE: capture[i] = rise;
        M_CAP_R4: begin
          capture[i] = rise & (s_q.unit[i].psc[1:0] == CAP_EVERY_4TH[1:0]);
          if (rise) begin
            s_d.unit[i].psc = {2'b00, s_q.unit[i].psc[1:0] + 2'h1};
          end
        end
        M_CAP_R16: begin
          capture[i] = rise & (s_q.unit[i].psc == CAP_EVERY_16TH);
          if (rise) begin
            s_d.unit[i].psc = s_q.unit[i].psc + 4'h1;
          end
        end
        default: capture[i] = 1'b0;
      endcase

      // Entry actions when the mode changes
      if (s_q.unit[i].mode != s_q.unit[i].mode_prev) begin
        case (s_q.unit[i].mode)
          M_SET_HIGH: s_d.unit[i].out = 1'b0;
          M_SET_LOW:  s_d.unit[i].out = 1'b1;
          default:    s_d.unit[i].out = s_q.unit[i].out;
        endcase
      end

      // Match actions
      if (match[i]) begin
        case (s_q.unit[i].mode)
          M_TOGGLE:   s_d.unit[i].out = ~s_q.unit[i].out;
          M_SET_HIGH: s_d.unit[i].out = 1'b1;
          M_SET_LOW:  s_d.unit[i].out = 1'b0;
          M_SPECIAL: begin
            if (uses_t3(s_q.timer3_control, i)) begin
              t3_ser = 1'b1;
            end else begin
              s_d.t1_reset = 1'b1;
            end
            // Only unit two starts the converter
            s_d.adc_start = (i == 1) & s_q.adc_en;
          end
          default:    s_d.unit[i].out = s_q.unit[i].out;
        endcase
      end

      // Pin drive only in output-changing compare modes; soft mode leaves port control
      s_d.unit[i].oe = (s_q.unit[i].mode == M_TOGGLE) | (s_q.unit[i].mode == M_SET_HIGH) |
                       (s_q.unit[i].mode == M_SET_LOW);
      // Duty value: low data byte over fraction bits
      s_d.unit[i].duty = (s_q.unit[i].mode[3:2] == 2'b11) ?
                         {s_q.unit[i].data[7:0], s_q.unit[i].dc} : 10'h000;
      // Disabled unit returns to reset
      if (s_q.unit[i].mode == M_OFF) begin
        s_d.unit[i].out     = 1'b0;
        s_d.unit[i].psc     = 4'h0;
        s_d.unit[i].eq_prev = 1'b0;
      end
    end

    // Special-event reset clears the count without touching the flag
    if (t3_ser) begin
      s_d.cnt = 16'h0000;
      s_d.pre = 3'h0;
    end

    // Read data, latched at the request edge; in 16-bit mode a low-byte read fills high buffer
    a_ofs = WB_ADR_I;
    case (a_ofs)
      OFS_T3_LOW:     rd = s_q.cnt[7:0];
      OFS_T3_HIGH:    rd = s_q.timer3_control[T3C_RD16] ? s_q.hi_buf : s_q.cnt[15:8];
      OFS_T3_CTRL:    rd = s_q.timer3_control;
      OFS_IRQ_REQ2:   rd = {6'h00, s_q.ovf_flag, 1'b0};
      OFS_IRQ_EN2:    rd = {6'h00, s_q.ovf_en, 1'b0};
      OFS_U1_CTRL:    rd = {2'b00, s_q.unit[0].dc, s_q.unit[0].mode};
      OFS_U1_LOW:     rd = s_q.unit[0].data[7:0];
      OFS_U1_HIGH:    rd = s_q.unit[0].data[15:8];
      OFS_U2_CTRL:    rd = {2'b00, s_q.unit[1].dc, s_q.unit[1].mode};
      OFS_U2_LOW:     rd = s_q.unit[1].data[7:0];
      OFS_U2_HIGH:    rd = s_q.unit[1].data[15:8];
      OFS_AUX_CTRL:   rd = {6'h00, s_q.adc_en, s_q.osc_en};
      OFS_UNIT_FLAGS: rd = {6'h00, s_q.unit[1].flag, s_q.unit[0].flag};
      default:        rd = 8'h00; // Unmapped reads zero
    endcase
    if (bus_req & ~s_q.ack & ~WB_WE_I) begin
      s_d.rdata = {24'h000000, rd};
      if ((a_ofs == OFS_T3_LOW) & s_q.timer3_control[T3C_RD16]) begin
        s_d.hi_buf = s_q.cnt[15:8];
      end
    end

    // Register writes; a count write overrides increment and special reset
    t3_wr = wr_en & ((a_ofs == OFS_T3_LOW) | ((a_ofs == OFS_T3_HIGH) & ~s_q.timer3_control[T3C_RD16]));
    if (wr_en) begin
      case (a_ofs)
        OFS_T3_LOW: begin
          s_d.pre = 3'h0; // Low-byte write clears prescaler
          if (s_q.timer3_control[T3C_RD16]) begin
            s_d.cnt = {s_q.hi_buf, WB_DAT_I[7:0]};
          end else begin
            s_d.cnt = {s_q.cnt[15:8], WB_DAT_I[7:0]};
          end
        end
        OFS_T3_HIGH: begin
          if (s_q.timer3_control[T3C_RD16]) begin
            s_d.hi_buf = WB_DAT_I[7:0];
          end else begin
            s_d.cnt = {WB_DAT_I[7:0], s_q.cnt[7:0]};
          end
        end
        OFS_T3_CTRL:    s_d.timer3_control    = WB_DAT_I[7:0];
        OFS_IRQ_REQ2:   s_d.ovf_flag = WB_DAT_I[IRQ_T3_OVF];
        OFS_IRQ_EN2:    s_d.ovf_en   = WB_DAT_I[IRQ_T3_OVF];
        OFS_AUX_CTRL: begin
          s_d.osc_en = WB_DAT_I[AUX_OSC_EN];
          s_d.adc_en = WB_DAT_I[AUX_ADC_EN];
        end
        OFS_UNIT_FLAGS: begin
          s_d.unit[0].flag = WB_DAT_I[0];
          s_d.unit[1].flag = WB_DAT_I[1];
        end
        default: begin
          // Unit blocks share one layout; unmapped writes are dropped
          for (int i = 0; i < 2; i++) begin
            if (a_ofs == OFS_U1_CTRL + UNIT_STRIDE * 8'(i)) begin
              s_d.unit[i].dc   = WB_DAT_I[UCTRL_DC +: 2];
              s_d.unit[i].mode = ccpt_mode_t'(WB_DAT_I[3:0]);
            end
            if (a_ofs == OFS_U1_LOW + UNIT_STRIDE * 8'(i)) begin
              s_d.unit[i].data[7:0] = WB_DAT_I[7:0];
            end
            if (a_ofs == OFS_U1_HIGH + UNIT_STRIDE * 8'(i)) begin
              s_d.unit[i].data[15:8] = WB_DAT_I[7:0];
            end
          end
        end
      endcase
    end

    // Hardware sets win over software clears; capture wins over data writes
    for (int i = 0; i < 2; i++) begin
      if (capture[i]) begin
        s_d.unit[i].data = uses_t3(s_q.timer3_control, i) ? s_q.cnt : TIMER1_COUNT;
      end
      if (match[i] | capture[i]) begin
        s_d.unit[i].flag = 1'b1;
      end
    end
    if (t3_wrap & ~t3_wr) begin
      s_d.ovf_flag = 1'b1;
    end
    s_d.irq = s_d.ovf_flag & s_d.ovf_en;
  end

  // State register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign WB_DAT_O      = s_q.rdata;
  assign WB_ACK_O      = s_q.ack;
  assign UNIT_PIN_OUT  = {s_q.unit[1].out, s_q.unit[0].out};
  assign UNIT_PIN_OE   = {s_q.unit[1].oe, s_q.unit[0].oe};
  assign UNIT_ONE_DUTY = s_q.unit[0].duty;
  assign UNIT_TWO_DUTY = s_q.unit[1].duty;
  assign ADC_START     = s_q.adc_start;
  assign TIMER1_RESET  = s_q.t1_reset;
  assign TIMER3_IRQ    = s_q.irq;

  // Checks on the behaviour above
  default clocking ast_cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  AST_WRAP_SETS_FLAG: assert property (
    (t3_wrap & ~t3_wr & ~t3_ser) |=> (s_q.ovf_flag && s_q.cnt == 16'h0000))
    else $error("Wrap did not clear count and set flag");

  AST_SER_CLEARS: assert property (
    (t3_ser & ~t3_wr) |=> (s_q.cnt == 16'h0000))
    else $error("Special event did not clear Timer3");

  AST_SER_NO_FLAG: assert property (
    (t3_ser & ~t3_wrap & ~s_q.ovf_flag & ~(wr_en & (WB_ADR_I == OFS_IRQ_REQ2))) |=> !s_q.ovf_flag)
    else $error("Special event set overflow flag");

  AST_WRITE_WINS: assert property (
    (t3_ser & wr_en & (WB_ADR_I == OFS_T3_LOW)) |=> (s_q.cnt[7:0] == $past(WB_DAT_I[7:0])))
    else $error("Special event overrode count write");

  AST_STOPPED_HOLDS: assert property (
    (~s_q.timer3_control[T3C_RUN] & ~t3_wr & ~t3_ser) |=> $stable(s_q.cnt))
    else $error("Timer3 moved while stopped");

  AST_ADC_FROM_UNIT2: assert property (
    ADC_START |-> $past(match[1] && s_q.unit[1].mode == M_SPECIAL && s_q.adc_en))
    else $error("Conversion start without unit two special event");

  AST_TOGGLE: assert property (
    (match[0] & (s_q.unit[0].mode == M_TOGGLE)) |=> (UNIT_PIN_OUT[0] != $past(UNIT_PIN_OUT[0])) && s_q.unit[0].flag)
    else $error("Toggle mode missed match");

  AST_OFF_RESETS: assert property (
    (s_q.unit[1].mode == M_OFF) [*2] |-> (!UNIT_PIN_OUT[1] && s_q.unit[1].psc == 4'h0))
    else $error("Disabled unit not in reset state");

  AST_RESERVED_QUIET: assert property (
    (s_q.unit[0].mode == M_RSV1 || s_q.unit[0].mode == M_RSV3) |-> (!match[0] && !capture[0]))
    else $error("Reserved mode produced an event");

  AST_ACK_PULSE: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("Ack held longer than one cycle");

endmodule

`default_nettype wire

//--- sim/ccpt_pins_model.sv
/*
  Far side of the block: capture pins, Timer1 value, oscillator, converter.
  Assumes the bench steers the capture level and the Timer1 value.
*/
`timescale 1ns/10ps
`default_nettype none

module ccpt_pins_model (
  // Clock
  input  wire logic        MCLK,
  // From block
  input  wire logic [1:0]  pin_out,
  input  wire logic [1:0]  pin_oe,
  input  wire logic        adc_start,
  // From bench
  input  wire logic        cap_lvl,
  input  wire logic [15:0] t1_val,
  // To block
  output logic      [1:0]  pin_in,
  output logic      [15:0] t1_count,
  output logic             osc_clk,
  // Event counts
  output logic      [15:0] adc_cnt,
  output logic      [15:0] tog_cnt
);
  logic [2:0] div; // Oscillator divider
  logic       last; // Pin level last cycle

  // Pin reads back our own drive while the block owns it
  assign pin_in[0] = pin_oe[0] ? pin_out[0] : cap_lvl;
  assign pin_in[1] = pin_oe[1] ? pin_out[1] : cap_lvl;
  assign t1_count  = t1_val;

  // Crystal stand-in divided down from MCLK, toggling every seven clocks
  initial begin
    div = 3'h0; osc_clk = 1'b0; adc_cnt = 16'h0; tog_cnt = 16'h0; last = 1'b0;
  end

  // Count conversions and toggles, spin oscillator
  always @(posedge MCLK) begin
    div <= (div == 3'h6) ? 3'h0 : div + 3'h1;
    if (div == 3'h6) osc_clk <= ~osc_clk;
    if (adc_start === 1'b1) adc_cnt <= adc_cnt + 16'h1;
    if (pin_out[0] !== last) tog_cnt <= tog_cnt + 16'h1;
    last <= pin_out[0];
  end
endmodule

`default_nettype wire

//--- sim/tb.sv
/*
  Self-checking bench for the Timer3 and capture/compare block.
  Assumes the block's package and the far-side model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ccpt_pkg::*;
  logic        MCLK, RESET_N, cyc, stb, we, cap;
  logic [7:0]  adr, r, m;
  logic [3:0]  sel;
  logic [31:0] wdat, WB_DAT_O;
  logic [15:0] t1, v, T1C, adc_n, tog_n, a0, g0;
  logic [1:0]  pin_in, pin_out, pin_oe;
  logic [9:0]  duty1, duty2;
  logic        WB_ACK_O, osc, adc, t1r, irq;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int          n_fail, checked, cycles, n;
  logic [7:0]  offs[7] = '{OFS_T3_CTRL, OFS_U1_CTRL, OFS_U1_LOW, OFS_U1_HIGH, OFS_U2_CTRL, OFS_U2_LOW, OFS_U2_HIGH};

  ccpt_timer3_ccp u_dut (.MCLK(MCLK), .RESET_N(RESET_N), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .SEC_OSC_CLK(osc), .TIMER1_COUNT(T1C), .UNIT_PIN_IN(pin_in), .UNIT_PIN_OUT(pin_out),
    .UNIT_PIN_OE(pin_oe), .UNIT_ONE_DUTY(duty1), .UNIT_TWO_DUTY(duty2), .ADC_START(adc),
    .TIMER1_RESET(t1r), .TIMER3_IRQ(irq));

  ccpt_pins_model u_far (.MCLK(MCLK), .pin_out(pin_out), .pin_oe(pin_oe), .adc_start(adc), .cap_lvl(cap),
    .t1_val(t1), .pin_in(pin_in), .t1_count(T1C), .osc_clk(osc), .adc_cnt(adc_n), .tog_cnt(tog_n));

  // Free-running bus clock
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  // Verdict and end of run
  task summarize();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Compare a settled output against its expectation
  task chk_v(input logic [15:0] got, input logic [15:0] e);
    checked++;
    if (got !== e) begin
      n_fail++;
      $display("ERROR %0t value %h expected %h", $time, got, e);
    end
  endtask

  // Classic cycle: hold until ack is sampled at a rising edge, release at that edge
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h0, d};
    do @(posedge MCLK); while (WB_ACK_O !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  // Read with its expectation noted first
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask

  // Read data checker: oldest note against the answer, taken at the ack edge
  always @(posedge MCLK) begin
    if (WB_ACK_O === 1'b1 && !we && exp_q.size() > 0) begin
      checked++;
      if (WB_DAT_O !== exp_q[0]) begin
        n_fail++;
        $display("ERROR %0t read %h expected %h", $time, WB_DAT_O, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end

  // Hang guard, well beyond the fewer than two thousand cycles used
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    RESET_N = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0; sel = 4'h0; wdat = 32'h0;
    cap = 1'b0; t1 = 16'h0;
    void'($urandom(32'h57c0457f));
    repeat (3) @(posedge MCLK);
    RESET_N <= 1'b1;
    // Reset values and read/write of Timer3 control and each unit's control and data bytes
    foreach (offs[i]) begin
      rd(offs[i], 8'h00);
      r = 8'($urandom);
      wb(1'b1, offs[i], r);
      rd(offs[i], (offs[i] == OFS_U1_CTRL || offs[i] == OFS_U2_CTRL) ? r & 8'h3f : r);
      wb(1'b1, offs[i], 8'h00);
    end
    wb(1'b1, 8'h40, 8'hff); // Unmapped place swallows writes
    rd(8'h40, 8'h00);
    // Wrap near the top sets the flag, enable gates the line
    wb(1'b1, OFS_T3_HIGH, 8'hff);
    wb(1'b1, OFS_T3_LOW, 8'hf0);
    wb(1'b1, OFS_IRQ_EN2, 8'h02);
    wb(1'b1, OFS_T3_CTRL, 8'h01);
    repeat (100) @(posedge MCLK);
    rd(OFS_IRQ_REQ2, 8'h02);
    rd(OFS_T3_HIGH, 8'h00);
    @(negedge MCLK) chk_v(16'(irq), 16'h1);
    wb(1'b1, OFS_IRQ_EN2, 8'h00);
    repeat (3) @(negedge MCLK);
    chk_v(16'(irq), 16'h0);
    // Stopped timer holds a written value
    wb(1'b1, OFS_T3_CTRL, 8'h00);
    wb(1'b1, OFS_T3_LOW, 8'h00);
    wb(1'b1, OFS_T3_HIGH, 8'h00);
    repeat (50) @(posedge MCLK);
    rd(OFS_T3_LOW, 8'h00);
    // Unit two resets Timer3 as a period; unit one toggles on its way
    wb(1'b1, OFS_IRQ_REQ2, 8'h00);
    wb(1'b1, OFS_U1_LOW, 8'h08);
    wb(1'b1, OFS_U1_CTRL, 8'h02);
    wb(1'b1, OFS_U2_LOW, 8'h10);
    wb(1'b1, OFS_U2_CTRL, 8'h0b);
    wb(1'b1, OFS_AUX_CTRL, 8'h02);
    wb(1'b1, OFS_UNIT_FLAGS, 8'h00);
    a0 = adc_n; g0 = tog_n;
    wb(1'b1, OFS_T3_CTRL, 8'h41);
    repeat (300) @(posedge MCLK);
    chk_v(16'(adc_n - a0 >= 16'h3), 16'h1);
    chk_v(16'(tog_n - g0 >= 16'h3), 16'h1);
    chk_v(16'(pin_oe[0]), 16'h1);
    rd(OFS_IRQ_REQ2, 8'h00);
    rd(OFS_T3_HIGH, 8'h00);
    rd(OFS_UNIT_FLAGS, 8'h03);
    // Entry level, then forced level on match
    for (m = 8'h08; m <= 8'h09; m++) begin
      wb(1'b1, OFS_T3_CTRL, 8'h40);
      wb(1'b1, OFS_T3_LOW, 8'h00);
      wb(1'b1, OFS_U1_CTRL, m);
      repeat (3) @(negedge MCLK);
      chk_v(16'(pin_out[0]), 16'(m[0]));
      wb(1'b1, OFS_T3_CTRL, 8'h41);
      repeat (100) @(negedge MCLK);
      chk_v(16'(pin_out[0]), 16'(!m[0]));
    end
    wb(1'b1, OFS_U1_CTRL, 8'h00);
    repeat (3) @(negedge MCLK);
    chk_v(16'(pin_oe[0]), 16'h0);
    // Duty value from low byte and fraction bits
    r = 8'($urandom);
    wb(1'b1, OFS_U1_LOW, r);
    wb(1'b1, OFS_U1_CTRL, 8'h3c);
    wb(1'b1, OFS_U2_LOW, ~r);
    wb(1'b1, OFS_U2_CTRL, 8'h1d);
    repeat (2) @(negedge MCLK);
    chk_v({6'h0, duty1}, {6'h0, r, 2'b11});
    chk_v({6'h0, duty2}, {6'h0, ~r, 2'b01});
    // Capture on each edge option from Timer1; off-edges see a decoy in the rising-edge modes
    wb(1'b1, OFS_T3_CTRL, 8'h00);
    wb(1'b1, OFS_U2_CTRL, 8'h00);
    for (m = 8'h04; m <= 8'h07; m++) begin
      wb(1'b1, OFS_U1_CTRL, 8'h00);
      wb(1'b1, OFS_U1_CTRL, m);
      n = (m == 8'h07) ? 16 : (m == 8'h06) ? 4 : 1;
      v = 16'($urandom);
      for (int k = 1; k <= n; k++) begin
        if (k == n) t1 <= v;
        cap <= 1'b1;
        repeat (8) @(posedge MCLK);
        if (m != 8'h04) t1 <= ~v;
        cap <= 1'b0;
        repeat (8) @(posedge MCLK);
      end
      rd(OFS_U1_LOW, v[7:0]);
      rd(OFS_U1_HIGH, v[15:8]);
    end
    // Select 01: unit one on Timer1 pulses the Timer1 reset once
    t1 <= v;
    wb(1'b1, OFS_T3_CTRL, 8'h08);
    wb(1'b1, OFS_U1_CTRL, 8'h0b);
    repeat (2) @(negedge MCLK);
    chk_v(16'(t1r), 16'h1);
    @(negedge MCLK) chk_v(16'(t1r), 16'h0);
    // Reserved modes stay quiet even at equality
    wb(1'b1, OFS_UNIT_FLAGS, 8'h00);
    wb(1'b1, OFS_U1_CTRL, 8'h01);
    wb(1'b1, OFS_U1_CTRL, 8'h03);
    rd(OFS_UNIT_FLAGS, 8'h00);
    // Oscillator at 1:8 over 16 of its periods (224 clocks) advances by two
    wb(1'b1, OFS_T3_HIGH, 8'h00);
    wb(1'b1, OFS_T3_LOW, 8'h00);
    wb(1'b1, OFS_AUX_CTRL, 8'h01);
    wb(1'b1, OFS_T3_CTRL, 8'h33);
    repeat (221) @(posedge MCLK);
    wb(1'b1, OFS_T3_CTRL, 8'h32);
    rd(OFS_T3_LOW, 8'h02);
    // Repeated count writes race the special reset; one lands on the match edge
    wb(1'b1, OFS_U2_LOW, 8'h40);
    wb(1'b1, OFS_U2_CTRL, 8'h0b);
    wb(1'b1, OFS_T3_CTRL, 8'h41);
    repeat (8) wb(1'b1, OFS_T3_LOW, 8'h3f);
    rd(OFS_IRQ_REQ2, 8'h00);
    summarize();
  end
endmodule

`default_nettype wire
